/* core/pmrd_map.svh */
// offsets, field positions, fixed control bits, read masks and timing counts of the program memory reader
`ifndef PMRD_MAP_SVH
`define PMRD_MAP_SVH
`define PMRD_OFS_CONTROL    3'h0
`define PMRD_OFS_DATA_LOW   3'h1
`define PMRD_OFS_DATA_HIGH  3'h2
`define PMRD_OFS_ADDR_LOW   3'h3
`define PMRD_OFS_ADDR_HIGH  3'h4
`define PMRD_RD_BIT         0
`define PMRD_CTRL_FIXED     8'h80
`define PMRD_ADDR_HIGH_MASK 8'h1F
`define PMRD_DATA_HIGH_MASK 8'h3F
`define PMRD_READ_CYCLES    2
`endif

/* core/pmrd_pkg.sv */
// types of the program memory reader
package pmrd_pkg;
  typedef enum logic [2:0] {
    PMRD_IDLE  = 3'b001,
    PMRD_WAIT1 = 3'b010,
    PMRD_WAIT2 = 3'b100
  } pmrd_state_t;
endpackage

/* core/pmrd_rom.sv */
// program memory array with registered read data
`timescale 1ns/1ps
module pmrd_rom #(
  parameter int AW = 13,
  parameter int DW = 14
) (
  input  wire logic          sys_clk,
  input  wire logic          wr_en,
  input  wire logic [AW-1:0] wr_addr,
  input  wire logic [DW-1:0] wr_data,
  input  wire logic [AW-1:0] rd_addr,
  output logic      [DW-1:0] rd_data
);
  logic [DW-1:0] mem [0:(1<<AW)-1];

  // loading port stands in for the programming path
  always_ff @(posedge sys_clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge sys_clk) begin
    rd_data <= mem[rd_addr];
  end
endmodule // pmrd_rom

/* core/pmrd_reader.sv */
// program memory reader: registers, read sequencer and instruction squash
`timescale 1ns/1ps
`include "pmrd_map.svh"

////////////////////////////////////////////////////////////////////////////////
// How it works
// - fetch word at address pair when launched
// - writing one to read bit launches read
// - read takes two cycles, two instructions ignored
// - fetched word loads high and low data
// - read bit resets zero, hardware-only clear
// - control bit7 reads one, bits 6-1 zero
// - high data bits 5-0, upper two zero
// - code protection never blocks these reads
// - high address bits 4-0, upper three zero
// - low data holds fetched bits 7-0
module pmrd_reader import pmrd_pkg::*; #(
  parameter int AW = 13,
  parameter int DW = 14
) (
  input  wire logic          sys_clk,
  input  wire logic          rst_n,
  input  wire logic          reg_wr,
  input  wire logic          reg_rd,
  input  wire logic [2:0]    reg_addr,
  input  wire logic [7:0]    reg_wdata,
  input  wire logic          code_protect,
  input  wire logic          prog_wr_en,
  input  wire logic [AW-1:0] prog_wr_addr,
  input  wire logic [DW-1:0] prog_wr_data,
  output logic      [7:0]    reg_rdata,
  output logic               squash_r,
  output logic               busy_r
);
  // only the 13-bit address, 14-bit word split is wired up below
  if (AW != 13 || DW != 14) begin : g_size_check
    $error("pmrd_reader serves only a 13-bit address and 14-bit word");
  end

  ////////////////////////////////////////////////////////////////////////////
  pmrd_state_t   state_r;
  logic          rd_bit_r;
  logic [7:0]    addr_low_r;
  logic [4:0]    addr_high_r;
  logic [7:0]    data_low_r;
  logic [5:0]    data_high_r;
  logic [AW-1:0] fetch_addr;
  logic [DW-1:0] rom_data;
  logic          launch;
  logic [7:0]    rdata_nxt;

  function automatic logic hit(input logic [2:0] a, input logic [2:0] ofs);
    return a == ofs;
  endfunction

  // launch ignored while busy: a second set inside the read changes nothing
  assign launch = reg_wr && hit(reg_addr, `PMRD_OFS_CONTROL)
                  && reg_wdata[`PMRD_RD_BIT] && (state_r == PMRD_IDLE);
  assign fetch_addr = {addr_high_r, addr_low_r};

  // code_protect is deliberately not looked at here
  pmrd_rom #(.AW(AW), .DW(DW)) u_rom (
    .sys_clk (sys_clk),
    .wr_en   (prog_wr_en),
    .wr_addr (prog_wr_addr),
    .wr_data (prog_wr_data),
    .rd_addr (fetch_addr),
    .rd_data (rom_data)
  );

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= PMRD_IDLE;
    end else begin
      unique case (state_r)
        PMRD_IDLE:  if (launch) state_r <= PMRD_WAIT1;
        PMRD_WAIT1: state_r <= PMRD_WAIT2;
        PMRD_WAIT2: state_r <= PMRD_IDLE;
        default:    state_r <= PMRD_IDLE;
      endcase
    end
  end

  // software cannot clear it; only the end of the read does
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_bit_r <= 1'b0;
    end else if (launch) begin
      rd_bit_r <= 1'b1;
    end else if (state_r == PMRD_WAIT2) begin
      rd_bit_r <= 1'b0;
    end
  end

  // the two instruction slots after the launch are dropped by the core
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      squash_r <= 1'b0;
      busy_r   <= 1'b0;
    end else begin
      squash_r <= launch || (state_r == PMRD_WAIT1);
      busy_r   <= launch || (state_r == PMRD_WAIT1);
    end
  end

  // address held during the read so the fetched word matches launch address
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      addr_low_r  <= 8'h00;
      addr_high_r <= 5'h00;
    end else if (reg_wr && state_r == PMRD_IDLE && !launch) begin
      if (hit(reg_addr, `PMRD_OFS_ADDR_LOW)) addr_low_r <= reg_wdata;
      if (hit(reg_addr, `PMRD_OFS_ADDR_HIGH)) begin
        addr_high_r <= reg_wdata[4:0];
      end
    end
  end

  // no reset: contents unknown until the first read or write
  always_ff @(posedge sys_clk) begin
    if (state_r == PMRD_WAIT2) begin
      data_low_r  <= rom_data[7:0];
      data_high_r <= rom_data[13:8];
    end else if (reg_wr && state_r == PMRD_IDLE) begin
      if (hit(reg_addr, `PMRD_OFS_DATA_LOW)) data_low_r <= reg_wdata;
      if (hit(reg_addr, `PMRD_OFS_DATA_HIGH)) data_high_r <= reg_wdata[5:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    rdata_nxt = 8'h00;
    unique case (reg_addr)
      `PMRD_OFS_CONTROL:   rdata_nxt = `PMRD_CTRL_FIXED | {7'h00, rd_bit_r};
      `PMRD_OFS_DATA_LOW:  rdata_nxt = data_low_r;
      `PMRD_OFS_DATA_HIGH: rdata_nxt = {2'b00, data_high_r} & `PMRD_DATA_HIGH_MASK;
      `PMRD_OFS_ADDR_LOW:  rdata_nxt = addr_low_r;
      `PMRD_OFS_ADDR_HIGH: rdata_nxt = {3'b000, addr_high_r} & `PMRD_ADDR_HIGH_MASK;
      default:             rdata_nxt = 8'h00;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata <= rdata_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // helper for the checks: length of the current busy run
  logic [1:0]    busy_len_r;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      busy_len_r <= 2'h0;
    end else if (busy_r) begin
      busy_len_r <= busy_len_r + 2'h1;
    end else begin
      busy_len_r <= 2'h0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  a_launch_busy: assert property (@(posedge sys_clk) disable iff (!rst_n)
    launch |=> busy_r ##1 busy_r ##1 !busy_r)
    else $error("busy not two cycles after launch");
  a_rd_set: assert property (@(posedge sys_clk) disable iff (!rst_n)
    launch |=> rd_bit_r)
    else $error("read bit not set by launch");
  a_rd_clear: assert property (@(posedge sys_clk) disable iff (!rst_n)
    launch |=> rd_bit_r ##1 rd_bit_r ##1 !rd_bit_r)
    else $error("read bit not cleared at read end");
  a_rd_hold: assert property (@(posedge sys_clk) disable iff (!rst_n)
    rd_bit_r && state_r != PMRD_WAIT2 |=> rd_bit_r)
    else $error("read bit cleared early");
  a_squash_two: assert property (@(posedge sys_clk) disable iff (!rst_n)
    launch |=> squash_r [*2] ##1 !squash_r)
    else $error("squash not two slots");
  a_data_load: assert property (@(posedge sys_clk) disable iff (!rst_n)
    state_r == PMRD_WAIT2 |=> {data_high_r, data_low_r} == $past(rom_data))
    else $error("data not loaded from fetched word");
  a_fetch_addr: assert property (@(posedge sys_clk) disable iff (!rst_n)
    launch |=> ##1 fetch_addr == $past(fetch_addr, 2))
    else $error("address moved during read");
  a_ctrl_fixed: assert property (@(posedge sys_clk) disable iff (!rst_n)
    reg_rd && reg_addr == `PMRD_OFS_CONTROL |=> reg_rdata[7:1] == 7'h40)
    else $error("control fixed bits wrong");
  a_high_zero: assert property (@(posedge sys_clk) disable iff (!rst_n)
    reg_rd && reg_addr == `PMRD_OFS_DATA_HIGH |=> reg_rdata[7:6] == 2'b00)
    else $error("data high upper bits not zero");
  a_addr_zero: assert property (@(posedge sys_clk) disable iff (!rst_n)
    reg_rd && reg_addr == `PMRD_OFS_ADDR_HIGH |=> reg_rdata[7:5] == 3'b000)
    else $error("address high upper bits not zero");
  a_protect_ok: assert property (@(posedge sys_clk) disable iff (!rst_n)
    launch && code_protect |=> ##1 state_r == PMRD_WAIT2)
    else $error("protection blocked read");
  a_busy_len: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $fell(busy_r) |-> busy_len_r == 2'(`PMRD_READ_CYCLES))
    else $error("busy run not the read length");
  a_addr_frozen: assert property (@(posedge sys_clk) disable iff (!rst_n)
    state_r != PMRD_IDLE |=> $stable(fetch_addr))
    else $error("address written during read");
  a_low_read: assert property (@(posedge sys_clk) disable iff (!rst_n)
    reg_rd && reg_addr == `PMRD_OFS_DATA_LOW |=> reg_rdata == $past(data_low_r))
    else $error("low data read wrong");
  a_rd_bit_read: assert property (@(posedge sys_clk) disable iff (!rst_n)
    reg_rd && reg_addr == `PMRD_OFS_CONTROL |=> reg_rdata[0] == $past(rd_bit_r))
    else $error("read bit not shown in control read");
  a_quiet_idle: assert property (@(posedge sys_clk) disable iff (!rst_n)
    state_r == PMRD_IDLE && !launch |=> !busy_r)
    else $error("busy without a launch");
  a_zero_no_launch: assert property (@(posedge sys_clk) disable iff (!rst_n)
    reg_wr && reg_addr == `PMRD_OFS_CONTROL && !reg_wdata[`PMRD_RD_BIT]
      && state_r == PMRD_IDLE |=> !rd_bit_r)
    else $error("read bit set by a zero write");

  c_read: cover property (@(posedge sys_clk) disable iff (!rst_n) launch ##3 !rd_bit_r);
  c_protected: cover property (@(posedge sys_clk) disable iff (!rst_n) launch && code_protect);
  c_back2back: cover property (@(posedge sys_clk) disable iff (!rst_n) launch ##3 launch);
  c_rd_ctrl: cover property (@(posedge sys_clk) disable iff (!rst_n)
    reg_rd && reg_addr == `PMRD_OFS_CONTROL && rd_bit_r);
  c_refused: cover property (@(posedge sys_clk) disable iff (!rst_n)
    reg_wr && state_r != PMRD_IDLE);
endmodule // pmrd_reader

/* testbench/pmrd_flash_model.sv */
// program array loader for the flash side, with a shadow copy
`timescale 1ns/1ps
module pmrd_flash_model #(
  parameter int AW = 13,
  parameter int DW = 14
) (
  input  wire logic          sys_clk,
  output logic               prog_wr_en,
  output logic      [AW-1:0] prog_wr_addr,
  output logic      [DW-1:0] prog_wr_data
);
  logic [DW-1:0] shadow [2**AW];
  initial begin
    prog_wr_en   = 1'b0;
    prog_wr_addr = '0;
    prog_wr_data = '0;
  end
  // released lines show the inverse, so a stale word never passes
  task automatic load(input logic [AW-1:0] a, input logic [DW-1:0] d);
    @(posedge sys_clk);
    prog_wr_en   <= 1'b1;
    prog_wr_addr <= a;
    prog_wr_data <= d;
    @(posedge sys_clk);
    prog_wr_en   <= 1'b0;
    prog_wr_addr <= ~a;
    prog_wr_data <= ~d;
    shadow[a] = d;
  endtask
endmodule // pmrd_flash_model

/* testbench/tb.sv */
// self-checking bench of the program memory reader
`timescale 1ns/1ps
`include "pmrd_map.svh"
module tb;
  logic        sys_clk, rst_n, reg_wr, reg_rd, code_protect, squash_r, busy_r, prog_wr_en;
  logic [2:0]  reg_addr;
  logic [7:0]  reg_wdata, reg_rdata;
  logic [12:0] prog_wr_addr, adr;
  logic [13:0] prog_wr_data, word;
  int          error_cnt, n_checks, cyc, sq_run;
  integer      seed = 32'hFD096602;
  pmrd_flash_model i_prog (.sys_clk(sys_clk), .prog_wr_en(prog_wr_en),
    .prog_wr_addr(prog_wr_addr), .prog_wr_data(prog_wr_data));
  pmrd_reader i_dut (.sys_clk(sys_clk), .rst_n(rst_n), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .code_protect(code_protect),
    .prog_wr_en(prog_wr_en), .prog_wr_addr(prog_wr_addr), .prog_wr_data(prog_wr_data),
    .reg_rdata(reg_rdata), .squash_r(squash_r), .busy_r(busy_r));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic complete_run();
    $display("checks %0d, mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %h, wanted %h", $time, got, exp);
    end
  endtask
  function automatic logic [7:0] ctrl_exp(input logic rd_busy);
    return `PMRD_CTRL_FIXED | {7'h00, rd_busy};
  endfunction
  function automatic logic [7:0] high_exp(input logic [13:0] w);
    return {2'b00, w[13:8]};
  endfunction
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd_chk(input logic [2:0] a, input logic [7:0] exp);
    @(posedge sys_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, exp);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  // squash length judged on its falling edge; busy must track it every cycle
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 5000) begin
      error_cnt++;
      complete_run();
    end
    if (squash_r === 1'b1) sq_run <= sq_run + 1;
    else if (sq_run != 0) begin
      chk(8'(sq_run), 8'h02);
      sq_run <= 0;
    end
    if (rst_n) chk({7'h00, busy_r}, {7'h00, squash_r});
  end
  initial begin
    {rst_n, reg_wr, reg_rd, code_protect, reg_addr, reg_wdata} = '0;
    repeat (10) @(posedge sys_clk);
    rst_n <= 1'b1;
    rd_chk(`PMRD_OFS_CONTROL, ctrl_exp(1'b0));
    for (int k = 5; k < 8; k++) rd_chk(3'(k), 8'h00);
    $display("test reset values ended");
    for (int i = 0; i < 24; i++) begin
      adr  = (i < 2) ? {13{i[0]}} : 13'($random(seed));
      word = (i < 2) ? {14{~i[0]}} : 14'($random(seed));
      i_prog.load(adr, word);
      code_protect <= i[1];
      wr(`PMRD_OFS_ADDR_HIGH, {3'($random(seed)), adr[12:8]});
      wr(`PMRD_OFS_ADDR_LOW, adr[7:0]);
      rd_chk(`PMRD_OFS_ADDR_HIGH, {3'h0, adr[12:8]});
      wr(`PMRD_OFS_CONTROL, {7'($random(seed)), 1'b0});
      rd_chk(`PMRD_OFS_CONTROL, ctrl_exp(1'b0));
      wr(`PMRD_OFS_CONTROL, {7'($random(seed)), 1'b1});
      #1 chk({6'h00, busy_r, squash_r}, 8'h03);
      // odd passes break the idle-slot habit on purpose
      if (i[0]) wr(`PMRD_OFS_ADDR_LOW, ~adr[7:0]);
      else rd_chk(`PMRD_OFS_CONTROL, ctrl_exp(1'b1));
      repeat (2) @(posedge sys_clk);
      #1 chk({6'h00, busy_r, squash_r}, 8'h00);
      rd_chk(`PMRD_OFS_DATA_LOW, i_prog.shadow[adr][7:0]);
      rd_chk(`PMRD_OFS_DATA_HIGH, high_exp(i_prog.shadow[adr]));
      rd_chk(`PMRD_OFS_ADDR_LOW, adr[7:0]);
      rd_chk(`PMRD_OFS_CONTROL, ctrl_exp(1'b0));
      $display("test read %0d ended", i);
    end
    complete_run();
  end
endmodule // tb
